// [design/link_monitor_pkg.sv]
// constants, register map and field layout of the link error monitor
//
// Overview of operation
// - count control requests unanswered within timeout
// - low twelve bits count, top bit flags overflow
// - count acknowledgements carrying the wrong tag
// - count malformed acknowledgements lacking end marker
// - count incomplete heartbeat packets
// - count every heartbeat period passing without heartbeat
// - four channels each keep own counters
// - lost stream packets counted, saturating at maximum
// - packet buffer overflows counted, saturating at maximum
// - report four-bit port causing buffer overflow
// - count image tag jumps, thirteen-bit range
// - count stream id mismatches, overflow-bit format
package link_monitor_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned CHANNELS      = 4;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned COUNT_W       = 13;
  localparam int unsigned SAT_W         = 12;
  localparam int unsigned PORT_W        = 4;
  localparam int unsigned SEL_W         = 2;
  localparam int unsigned TAG_W         = 8;
  localparam int unsigned IMG_TAG_W     = 16;
  localparam int unsigned SID_W         = 8;
  localparam int unsigned TIMER_W       = 32;
  localparam int unsigned EVENTS        = 9;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned ACK_TIMEOUT_MS = 200;
  localparam int unsigned HB_PERIOD_MS  = 100;
  localparam int unsigned ACK_TIMEOUT_CYCLES =
    ACK_TIMEOUT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned HB_PERIOD_CYCLES =
    HB_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // counter limits and fields
  // ----------------------------------------------------------------
  localparam logic [SAT_W-1:0]   COUNT_FULL    = 12'hfff;
  localparam logic [COUNT_W-1:0] SAT12_MAX     = 13'h0fff;
  localparam logic [COUNT_W-1:0] SAT13_MAX     = 13'h1fff;
  localparam int unsigned        OVF_BIT       = 12;
  localparam int unsigned        CTRL_SEL_LSB  = 0;
  localparam int unsigned        CTRL_HBEN_LSB = 4;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONTROL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ACK_LOST      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TAG_MISMATCH  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ACK_MALFORMED = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_HB_MALFORMED  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_HB_OVERDUE    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LOST_PACKET   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PBO_COUNT     = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PBO_PORT      = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IMG_TAG_JUMP  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_SID_MISMATCH  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS    = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK      = 8'h30;

  // ----------------------------------------------------------------
  // interrupt status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned EV_ACK_LOST      = 0;
  localparam int unsigned EV_TAG_MISMATCH  = 1;
  localparam int unsigned EV_ACK_MALFORMED = 2;
  localparam int unsigned EV_HB_MALFORMED  = 3;
  localparam int unsigned EV_HB_OVERDUE    = 4;
  localparam int unsigned EV_LOST_PACKET   = 5;
  localparam int unsigned EV_PBO           = 6;
  localparam int unsigned EV_IMG_TAG_JUMP  = 7;
  localparam int unsigned EV_SID_MISMATCH  = 8;

endpackage : link_monitor_pkg

// [design/link_error_monitor.sv]
// link error monitor: per-channel and stream error counters, regs, irq
`timescale 1ns/100ps
`default_nettype none
module link_error_monitor
#(
  parameter int unsigned ACK_TIMEOUT_CYCLES =
    link_monitor_pkg::ACK_TIMEOUT_CYCLES,
  parameter int unsigned HB_PERIOD_CYCLES   =
    link_monitor_pkg::HB_PERIOD_CYCLES
)
(
  input  wire logic                                   clk,
  input  wire logic                                   reset,
  input  wire logic [link_monitor_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [link_monitor_pkg::DATA_W-1:0]    reg_wr_data,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output var  logic [link_monitor_pkg::DATA_W-1:0]    reg_rd_data,
  output logic                                        irq,
  input  wire logic [link_monitor_pkg::CHANNELS-1:0]  ctrl_req_sent,
  input  wire logic [link_monitor_pkg::CHANNELS-1:0]
                    [link_monitor_pkg::TAG_W-1:0]     ctrl_req_tag,
  input  wire logic [link_monitor_pkg::CHANNELS-1:0]  ack_received,
  input  wire logic [link_monitor_pkg::CHANNELS-1:0]
                    [link_monitor_pkg::TAG_W-1:0]     ack_tag,
  input  wire logic [link_monitor_pkg::CHANNELS-1:0]  ack_complete,
  input  wire logic [link_monitor_pkg::CHANNELS-1:0]  heartbeat_received,
  input  wire logic [link_monitor_pkg::CHANNELS-1:0]  heartbeat_complete,
  input  wire logic                                   packet_lost,
  input  wire logic                                   buffer_overflow,
  input  wire logic [link_monitor_pkg::PORT_W-1:0]    overflow_port,
  input  wire logic                                   image_header,
  input  wire logic [link_monitor_pkg::IMG_TAG_W-1:0] image_tag,
  input  wire logic [link_monitor_pkg::SID_W-1:0]     header_stream_id,
  input  wire logic                                   stream_packet,
  input  wire logic [link_monitor_pkg::SID_W-1:0]     packet_stream_id
);

  localparam int unsigned NCH = link_monitor_pkg::CHANNELS;
  localparam int unsigned CW  = link_monitor_pkg::COUNT_W;
  localparam int unsigned TW  = link_monitor_pkg::TIMER_W;
  localparam int unsigned NEV = link_monitor_pkg::EVENTS;
  localparam logic [TW-1:0] ACK_LAST = TW'(ACK_TIMEOUT_CYCLES - 1);
  localparam logic [TW-1:0] HB_LAST  = TW'(HB_PERIOD_CYCLES - 1);

  // ----------------------------------------------------------------
  // counter arithmetic
  // ----------------------------------------------------------------
  // count wraps into zero while the top bit latches for good
  function automatic logic [CW-1:0] inc_ovf(input logic [CW-1:0] c);
    logic [CW-1:0] r;
    r = c;
    if (c[link_monitor_pkg::SAT_W-1:0] == link_monitor_pkg::COUNT_FULL)
    begin
      r = {1'b1, {link_monitor_pkg::SAT_W{1'b0}}};
    end
    else
    begin
      r = c + 13'h0001;
    end
    return r;
  endfunction : inc_ovf

  function automatic logic [CW-1:0] inc_sat(input logic [CW-1:0] c,
                                            input logic [CW-1:0] max);
    return (c == max) ? c : c + 13'h0001;
  endfunction : inc_sat

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [link_monitor_pkg::SEL_W-1:0] channel_select;
  logic [NCH-1:0]                     hb_enable;
  logic [NEV-1:0]                     int_status;
  logic [NEV-1:0]                     int_mask;
  logic [NEV-1:0]                     events;

  wire logic wr_control = reg_wr && reg_addr == link_monitor_pkg::OFS_CONTROL;
  wire logic wr_status  = reg_wr &&
                          reg_addr == link_monitor_pkg::OFS_INT_STATUS;
  wire logic wr_mask    = reg_wr && reg_addr == link_monitor_pkg::OFS_INT_MASK;
  wire logic [NEV-1:0] status_clear =
    wr_status ? reg_wr_data[NEV-1:0] : {NEV{1'b0}};
  // a new event beats a clear landing in the same cycle
  wire logic [NEV-1:0] next_int_status = (int_status & ~status_clear) | events;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      channel_select <= '0;
      hb_enable      <= '0;
      int_status     <= '0;
      int_mask       <= '0;
    end
    else
    begin
      if (wr_control)
      begin
        channel_select <= reg_wr_data[link_monitor_pkg::CTRL_SEL_LSB +:
                                      link_monitor_pkg::SEL_W];
        hb_enable      <= reg_wr_data[link_monitor_pkg::CTRL_HBEN_LSB +: NCH];
      end
      if (wr_mask)
      begin
        int_mask <= reg_wr_data[NEV-1:0];
      end
      int_status <= next_int_status;
    end
  end

  assign irq = |(int_status & int_mask);

  // ----------------------------------------------------------------
  // per-channel control and heartbeat watch
  // ----------------------------------------------------------------
  logic [CW-1:0]  ch_ack_lost      [NCH];
  logic [CW-1:0]  ch_tag_mismatch  [NCH];
  logic [CW-1:0]  ch_ack_malformed [NCH];
  logic [CW-1:0]  ch_hb_malformed  [NCH];
  logic [CW-1:0]  ch_hb_overdue    [NCH];
  logic [NCH-1:0] ev_lost;
  logic [NCH-1:0] ev_tag;
  logic [NCH-1:0] ev_ack_bad;
  logic [NCH-1:0] ev_hb_bad;
  logic [NCH-1:0] ev_hb_late;

  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (reset);

  for (genvar g = 0; g < NCH; g++)
  begin : chan
    logic                                pending;
    logic [TW-1:0]                       ack_timer;
    logic [TW-1:0]                       hb_timer;
    logic [link_monitor_pkg::TAG_W-1:0]  expected_tag;
    logic [CW-1:0]                       lost;
    logic [CW-1:0]                       tag_bad;
    logic [CW-1:0]                       ack_bad;
    logic [CW-1:0]                       hb_bad;
    logic [CW-1:0]                       hb_late;

    // an ack ends the wait; a malformed one leaves the request open
    wire logic good_ack = ack_received[g] && ack_complete[g];
    wire logic timeout  = pending && ack_timer == ACK_LAST && !good_ack;
    wire logic tag_err  = pending && good_ack &&
                          ack_tag[g] != expected_tag;
    wire logic ack_err  = ack_received[g] && !ack_complete[g];
    wire logic hb_err   = heartbeat_received[g] && !heartbeat_complete[g];
    wire logic hb_ok    = heartbeat_received[g] && heartbeat_complete[g];
    wire logic hb_due   = hb_enable[g] && !hb_ok && hb_timer == HB_LAST;

    assign ev_lost[g]    = timeout;
    assign ev_tag[g]     = tag_err;
    assign ev_ack_bad[g] = ack_err;
    assign ev_hb_bad[g]  = hb_err;
    assign ev_hb_late[g] = hb_due;

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        pending      <= 1'b0;
        ack_timer    <= '0;
        expected_tag <= '0;
      end
      else if (ctrl_req_sent[g])
      begin
        pending      <= 1'b1;
        ack_timer    <= '0;
        expected_tag <= ctrl_req_tag[g];
      end
      else if (good_ack || timeout)
      begin
        pending      <= 1'b0;
        ack_timer    <= '0;
      end
      else if (pending)
      begin
        ack_timer    <= ack_timer + 32'h1;
      end
    end

    // a disabled channel has no camera to expect heartbeats from
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        hb_timer <= '0;
      end
      else if (!hb_enable[g] || hb_ok || hb_due)
      begin
        hb_timer <= '0;
      end
      else
      begin
        hb_timer <= hb_timer + 32'h1;
      end
    end

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        lost    <= '0;
        tag_bad <= '0;
        ack_bad <= '0;
        hb_bad  <= '0;
        hb_late <= '0;
      end
      else
      begin
        if (timeout) lost <= inc_ovf(lost);
        if (tag_err) tag_bad <= inc_ovf(tag_bad);
        if (ack_err) ack_bad <= inc_ovf(ack_bad);
        if (hb_err)  hb_bad <= inc_ovf(hb_bad);
        if (hb_due)  hb_late <= inc_ovf(hb_late);
      end
    end

    assign ch_ack_lost[g]      = lost;
    assign ch_tag_mismatch[g]  = tag_bad;
    assign ch_ack_malformed[g] = ack_bad;
    assign ch_hb_malformed[g]  = hb_bad;
    assign ch_hb_overdue[g]    = hb_late;

    lost_count_a: assert property (timeout && !lost[12] &&
      lost[11:0] != 12'hfff |=> lost[11:0] == $past(lost[11:0]) + 12'h1)
      else $error("lost ack not counted");
    ovf_wrap_a: assert property (hb_due && hb_late[11:0] == 12'hfff
      |=> hb_late[12] && hb_late[11:0] == 12'h000)
      else $error("overflow bit not set on wrap");
    ovf_sticky_a: assert property (tag_bad[12] |=> tag_bad[12])
      else $error("overflow bit cleared");
    tag_check_a: assert property (ack_received[g] &&
      ack_complete[g] && pending && ack_tag[g] != expected_tag &&
      tag_bad[12:0] != 13'h0fff |=> tag_bad != $past(tag_bad))
      else $error("tag mismatch not counted");
    ack_malformed_a: assert property (ack_received[g] &&
      !ack_complete[g] |=> ack_bad != $past(ack_bad) && pending ==
      $past(pending || ctrl_req_sent[g]) || $past(pending && ack_timer ==
      ACK_LAST))
      else $error("malformed ack mishandled");
    hb_period_a: assert property (hb_enable[g] &&
      hb_timer == HB_LAST && !heartbeat_received[g] |=> hb_timer == 32'h0 &&
      hb_late != $past(hb_late))
      else $error("overdue heartbeat not counted");
  end

  assign events[link_monitor_pkg::EV_ACK_LOST]      = |ev_lost;
  assign events[link_monitor_pkg::EV_TAG_MISMATCH]  = |ev_tag;
  assign events[link_monitor_pkg::EV_ACK_MALFORMED] = |ev_ack_bad;
  assign events[link_monitor_pkg::EV_HB_MALFORMED]  = |ev_hb_bad;
  assign events[link_monitor_pkg::EV_HB_OVERDUE]    = |ev_hb_late;

  // ----------------------------------------------------------------
  // stream counters
  // ----------------------------------------------------------------
  logic [CW-1:0]                          lost_stream_packet_counter;
  logic [CW-1:0]                          packet_buffer_overflow_counter;
  logic [link_monitor_pkg::PORT_W-1:0]    packet_buffer_overflow_port;
  logic [CW-1:0]                          image_tag_jump_counter;
  logic [CW-1:0]                          stream_id_mismatch_counter;
  logic                                   header_seen;
  logic [link_monitor_pkg::IMG_TAG_W-1:0] last_image_tag;
  logic [link_monitor_pkg::SID_W-1:0]     current_stream_id;

  // the first header after reset has nothing to be compared with
  wire logic tag_jump = image_header && header_seen &&
                        image_tag != last_image_tag + 16'h0001;
  wire logic sid_err  = stream_packet && header_seen &&
                        packet_stream_id != current_stream_id;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      header_seen       <= 1'b0;
      last_image_tag    <= '0;
      current_stream_id <= '0;
    end
    else if (image_header)
    begin
      header_seen       <= 1'b1;
      last_image_tag    <= image_tag;
      current_stream_id <= header_stream_id;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lost_stream_packet_counter     <= '0;
      packet_buffer_overflow_counter <= '0;
      packet_buffer_overflow_port    <= '0;
      image_tag_jump_counter         <= '0;
      stream_id_mismatch_counter     <= '0;
    end
    else
    begin
      if (packet_lost)
        lost_stream_packet_counter <= inc_sat(lost_stream_packet_counter,
          link_monitor_pkg::SAT12_MAX);
      if (buffer_overflow)
      begin
        packet_buffer_overflow_counter <= inc_sat(
          packet_buffer_overflow_counter, link_monitor_pkg::SAT12_MAX);
        packet_buffer_overflow_port <= overflow_port;
      end
      if (tag_jump)
        image_tag_jump_counter <= inc_sat(image_tag_jump_counter,
          link_monitor_pkg::SAT13_MAX);
      if (sid_err)
        stream_id_mismatch_counter <= inc_ovf(stream_id_mismatch_counter);
    end
  end

  assign events[link_monitor_pkg::EV_LOST_PACKET]  = packet_lost;
  assign events[link_monitor_pkg::EV_PBO]          = buffer_overflow;
  assign events[link_monitor_pkg::EV_IMG_TAG_JUMP] = tag_jump;
  assign events[link_monitor_pkg::EV_SID_MISMATCH] = sid_err;

  lost_sat_a: assert property (packet_lost &&
    lost_stream_packet_counter == 13'h0fff
    |=> lost_stream_packet_counter == 13'h0fff)
    else $error("lost packet counter left its range");
  pbo_port_a: assert property (buffer_overflow |=>
    packet_buffer_overflow_port == $past(overflow_port))
    else $error("overflow port not captured");
  sid_count_a: assert property (stream_packet && header_seen &&
    packet_stream_id != current_stream_id && !image_header
    ##1 (!stream_packet)[*2] |-> ##1
    stream_id_mismatch_counter != $past(stream_id_mismatch_counter, 3))
    else $error("stream id mismatch not counted");

  // ----------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------
  // counters are read only: a write to their offsets changes nothing
  wire logic [link_monitor_pkg::ADDR_W-1:0] a = reg_addr;
  wire logic [CW-1:0] sel_lost = ch_ack_lost[channel_select];
  wire logic [CW-1:0] sel_tag  = ch_tag_mismatch[channel_select];
  wire logic [CW-1:0] sel_ackm = ch_ack_malformed[channel_select];
  wire logic [CW-1:0] sel_hbm  = ch_hb_malformed[channel_select];
  wire logic [CW-1:0] sel_hbo  = ch_hb_overdue[channel_select];
  wire logic [link_monitor_pkg::DATA_W-1:0] control_word =
    {24'h000000, hb_enable, 2'b00, channel_select};
  wire logic [link_monitor_pkg::DATA_W-1:0] next_reg_rd_data =
    !reg_rd ? 32'h0 :
    a == link_monitor_pkg::OFS_CONTROL       ? control_word :
    a == link_monitor_pkg::OFS_ACK_LOST      ? {19'h0, sel_lost} :
    a == link_monitor_pkg::OFS_TAG_MISMATCH  ? {19'h0, sel_tag} :
    a == link_monitor_pkg::OFS_ACK_MALFORMED ? {19'h0, sel_ackm} :
    a == link_monitor_pkg::OFS_HB_MALFORMED  ? {19'h0, sel_hbm} :
    a == link_monitor_pkg::OFS_HB_OVERDUE    ? {19'h0, sel_hbo} :
    a == link_monitor_pkg::OFS_LOST_PACKET   ?
      {19'h0, lost_stream_packet_counter} :
    a == link_monitor_pkg::OFS_PBO_COUNT     ?
      {19'h0, packet_buffer_overflow_counter} :
    a == link_monitor_pkg::OFS_PBO_PORT      ?
      {28'h0, packet_buffer_overflow_port} :
    a == link_monitor_pkg::OFS_IMG_TAG_JUMP  ?
      {19'h0, image_tag_jump_counter} :
    a == link_monitor_pkg::OFS_SID_MISMATCH  ?
      {19'h0, stream_id_mismatch_counter} :
    a == link_monitor_pkg::OFS_INT_STATUS    ? {23'h0, int_status} :
    a == link_monitor_pkg::OFS_INT_MASK      ? {23'h0, int_mask} :
    32'h0;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rd_data <= '0;
    else
      reg_rd_data <= next_reg_rd_data;
  end

  sel_read_a: assert property (reg_rd &&
    reg_addr == link_monitor_pkg::OFS_ACK_LOST
    |=> reg_rd_data[12:0] == $past(ch_ack_lost[channel_select]))
    else $error("selected channel not read back");
  irq_event_a: assert property ((events & int_mask) != 9'h0
    |=> (irq || $past(wr_mask)) &&
    (int_status & $past(events)) == $past(events))
    else $error("unmasked event raised no interrupt");

endmodule : link_error_monitor
`default_nettype wire

// [test/camera_model.sv]
// camera side model: control acks, heartbeats and stream traffic
`timescale 1ns/100ps
`default_nettype none
module camera_model
(
  input  wire logic            clk,
  output var  logic [3:0]      ack_received,
  output var  logic [3:0][7:0] ack_tag,
  output var  logic [3:0]      ack_complete,
  output var  logic [3:0]      heartbeat_received,
  output var  logic [3:0]      heartbeat_complete,
  output var  logic            packet_lost,
  output var  logic            buffer_overflow,
  output var  logic [3:0]      overflow_port,
  output var  logic            image_header,
  output var  logic [15:0]     image_tag,
  output var  logic [7:0]      header_stream_id,
  output var  logic            stream_packet,
  output var  logic [7:0]      packet_stream_id
);
  // -----------------------------------------------------------
  // packet senders; released fields show the inverse value
  // -----------------------------------------------------------
  initial
  begin
    {ack_received, ack_tag, ack_complete, heartbeat_received} = '0;
    {heartbeat_complete, packet_lost, buffer_overflow} = '0;
    {overflow_port, image_header, image_tag, header_stream_id} = '0;
    {stream_packet, packet_stream_id} = '0;
  end
  task automatic ack(input int c, input logic [7:0] t, input logic k);
    @(posedge clk);
    ack_received[c] <= 1'b1;
    ack_tag[c]      <= t;
    ack_complete[c] <= k;
    @(posedge clk);
    ack_received[c] <= 1'b0;
    ack_tag[c]      <= ~t;
    ack_complete[c] <= ~k;
  endtask : ack
  // caller spaces these well inside the period
  task automatic hb(input int c, input logic k);
    @(posedge clk);
    heartbeat_received[c] <= 1'b1;
    heartbeat_complete[c] <= k;
    @(posedge clk);
    heartbeat_received[c] <= 1'b0;
    heartbeat_complete[c] <= ~k;
  endtask : hb
  task automatic hdr(input logic [15:0] t, input logic [7:0] s);
    @(posedge clk);
    image_header     <= 1'b1;
    image_tag        <= t;
    header_stream_id <= s;
    @(posedge clk);
    image_header     <= 1'b0;
    image_tag        <= ~t;
    header_stream_id <= ~s;
  endtask : hdr
  // held high n cycles: one event per cycle
  task automatic burst(input logic [2:0] s, input logic [7:0] v, int n);
    @(posedge clk);
    {stream_packet, buffer_overflow, packet_lost} <= s;
    packet_stream_id <= v;
    overflow_port    <= v[3:0];
    repeat (n) @(posedge clk);
    {stream_packet, buffer_overflow, packet_lost} <= 3'b000;
    packet_stream_id <= ~v;
    overflow_port    <= ~v[3:0];
  endtask : burst
endmodule : camera_model
`default_nettype wire

// [test/testbench.sv]
// self-checking bench of the link error monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic            clk, reset, reg_wr, reg_rd, irq, packet_lost;
  logic            buffer_overflow, image_header, stream_packet;
  logic [7:0]      reg_addr, header_stream_id, packet_stream_id;
  logic [31:0]     reg_wr_data, reg_rd_data;
  logic [3:0]      ctrl_req_sent, ack_received, ack_complete;
  logic [3:0]      heartbeat_received, heartbeat_complete, overflow_port;
  logic [3:0][7:0] ctrl_req_tag, ack_tag;
  logic [15:0]     image_tag;
  int              error_cnt, check_count, cyc;
  // short counts keep the run small
  link_error_monitor #(.ACK_TIMEOUT_CYCLES(20), .HB_PERIOD_CYCLES(10)) dut
  (.clk, .reset, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data,
   .irq, .ctrl_req_sent, .ctrl_req_tag, .ack_received, .ack_tag,
   .ack_complete, .heartbeat_received, .heartbeat_complete, .packet_lost,
   .buffer_overflow, .overflow_port, .image_header, .image_tag,
   .header_stream_id, .stream_packet, .packet_stream_id);
  camera_model cam
  (.clk, .ack_received, .ack_tag, .ack_complete, .heartbeat_received,
   .heartbeat_complete, .packet_lost, .buffer_overflow, .overflow_port,
   .image_header, .image_tag, .header_stream_id, .stream_packet,
   .packet_stream_id);
  // -----------------------------------------------------------
  // bus tasks
  // -----------------------------------------------------------
  task automatic cmp(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr      <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr      <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 cmp($sformatf("reg %h", a), e, reg_rd_data);
  endtask : rd
  task automatic req(input int c, input logic [7:0] t);
    @(posedge clk);
    ctrl_req_sent[c] <= 1'b1;
    ctrl_req_tag[c]  <= t;
    @(posedge clk);
    ctrl_req_sent[c] <= 1'b0;
  endtask : req
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_regs;
    for (int a = 0; a <= 'h30; a += 4)
      rd(8'(a), 32'h0);
    rd(8'hfc, 32'h0);
    wr(8'h18, 32'h5);
    rd(8'h18, 32'h0);
  endtask : t_regs
  task automatic t_ctrl;
    req(0, 8'h33);
    cam.ack(0, 8'h33, 1'b1);
    wr(8'h00, 32'h2);
    req(2, 8'h11);
    repeat (22) @(posedge clk);
    rd(8'h04, 32'h1);
    wr(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    req(1, 8'h05);
    cam.ack(1, 8'h05, 1'b0);
    cam.ack(1, 8'h06, 1'b1);
    wr(8'h00, 32'h1);
    rd(8'h0c, 32'h1);
    rd(8'h08, 32'h1);
  endtask : t_ctrl
  task automatic t_hb;
    wr(8'h00, 32'h83);
    cam.hb(3, 1'b0);
    repeat (4)
    begin
      repeat (3) @(posedge clk);
      cam.hb(3, 1'b1);
    end
    // silence long enough for exactly two periods
    repeat (24) @(posedge clk);
    wr(8'h00, 32'h03);
    rd(8'h00, 32'h3);
    rd(8'h10, 32'h1);
    rd(8'h14, 32'h2);
  endtask : t_hb
  task automatic t_stream;
    cam.hdr(16'hfffe, 8'h03);
    cam.hdr(16'hffff, 8'h03);
    cam.hdr(16'h0000, 8'h03);
    cam.hdr(16'h0005, 8'h03);
    cam.burst(3'b100, 8'h03, 1);
    cam.burst(3'b100, 8'h04, 1);
    rd(8'h24, 32'h1);
    rd(8'h28, 32'h1);
    cam.burst(3'b010, 8'h09, 2);
    rd(8'h1c, 32'h2);
    rd(8'h20, 32'h9);
  endtask : t_stream
  task automatic t_sat;
    cam.burst(3'b001, 8'h00, 4097);
    rd(8'h18, 32'hfff);
    cam.burst(3'b100, 8'h04, 4095);
    rd(8'h28, 32'h1000);
    cam.burst(3'b100, 8'h04, 2);
    rd(8'h28, 32'h1002);
    cmp("sid ovf", 32'h1, {31'h0, reg_rd_data[12]});
    cam.burst(3'b010, 8'h0f, 4095);
    rd(8'h1c, 32'hfff);
    rd(8'h20, 32'hf);
  endtask : t_sat
  task automatic t_irq;
    rd(8'h2c, 32'h1ff);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(8'h30, 32'h10);
    #1 cmp("irq", 32'h1, {31'h0, irq});
    wr(8'h2c, 32'h10);
    #1 cmp("irq", 32'h0, {31'h0, irq});
    rd(8'h2c, 32'h1ef);
  endtask : t_irq
  // a mid-run reset is the only thing that clears counters
  task automatic t_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h28, 32'h0);
    rd(8'h2c, 32'h0);
  endtask : t_reset
  task automatic end_of_test;
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, well above the sum of all scenarios
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  initial
  begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wr_data} = '0;
    {ctrl_req_sent, ctrl_req_tag} = '0;
    reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_ctrl();
    t_hb();
    t_stream();
    t_sat();
    t_irq();
    t_reset();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
